// ---- addr_data_pin_mux.sv ----
// address/data pin multiplexer of the external parallel port
//
// How it works
// - The pins go to the flag function only when control bit 20 is set and the port is off.
// - In flag use pins 0-7 are flags 8-15 and pins 8-15 are flags 0-7.
// - In 8-bit width with the strobe up, address 15-8 goes low and 23-16 goes high.
// - In 8-bit width after the strobe, data 7-0 goes low and address 7-0 goes high.
// - In 16-bit width with the strobe up, address 7-0 goes low and 15-8 goes high.
// - In 16-bit width after the strobe, data 15-0 occupies all sixteen pins.
// - Read, write and latch strobes are always driven, never released.
`timescale 1ns/1ps
module addr_data_pin_mux (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [31:0] systemControlReg,
  input  wire logic        portEnable,
  input  wire logic        extPortWidthMode,
  input  wire logic        portAle,
  input  wire logic        portRdN,
  input  wire logic        portWrN,
  input  wire logic [23:0] portAddr,
  input  wire logic [15:0] portWrData,
  output logic      [15:0] portRdData,
  input  wire logic [15:0] flagOut,
  input  wire logic [15:0] flagOe,
  output logic      [15:0] flagIn,
  output logic             flagUse,
  input  wire logic [15:0] adIn,
  output logic      [15:0] adOut,
  output logic      [15:0] adOe,
  output logic             aleOut,
  output logic             rdOutN,
  output logic             wrOutN
);
  adpm_flag_if fl ();

  logic        selFlag;
  logic [15:0] next_adOut;
  logic [15:0] next_adOe;
  logic [7:0]  lowDataOe;

  assign fl.flagOut = flagOut;
  assign fl.flagOe  = flagOe;
  assign fl.pinIn   = adIn;

  adpm_flag_map uMap (
    .fl (fl.mapper)
  );

  assign selFlag = systemControlReg[adpm_pkg::SYSTEM_CONTROL_REG_FLAG_EN] & ~portEnable;
  // data bytes are driven only while a write is under way
  assign lowDataOe = portWrN ? adpm_pkg::BYTE_RELEASE : adpm_pkg::BYTE_DRIVE;

  // next pin state; flag use wins unless the port is enabled
  always_comb begin
    next_adOut = '0;
    next_adOe  = '0;
    if (selFlag) begin
      next_adOut = fl.pinOut;
      next_adOe  = fl.pinOe;
    end else if (portEnable) begin
      if (portAle) begin
        next_adOe = {adpm_pkg::BYTE_DRIVE, adpm_pkg::BYTE_DRIVE};
        if (extPortWidthMode == adpm_pkg::WIDTH_8BIT) begin
          next_adOut = portAddr[23:8];
        end else begin
          next_adOut = portAddr[15:0];
        end
      end else if (extPortWidthMode == adpm_pkg::WIDTH_8BIT) begin
        next_adOut = {portAddr[7:0], portWrData[7:0]};
        next_adOe  = {adpm_pkg::BYTE_DRIVE, lowDataOe};
      end else begin
        next_adOut = portWrData;
        next_adOe  = {lowDataOe, lowDataOe};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      adOut <= '0;
      adOe  <= '0;
    end else begin
      adOut <= next_adOut;
      adOe  <= next_adOe;
    end
  end

  // strobes have no enable at all: always driven, idle outside port use
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aleOut <= adpm_pkg::ALE_IDLE;
      rdOutN <= adpm_pkg::STROBE_IDLE_N;
      wrOutN <= adpm_pkg::STROBE_IDLE_N;
    end else if (portEnable) begin
      aleOut <= portAle;
      rdOutN <= portRdN;
      wrOutN <= portWrN;
    end else begin
      aleOut <= adpm_pkg::ALE_IDLE;
      rdOutN <= adpm_pkg::STROBE_IDLE_N;
      wrOutN <= adpm_pkg::STROBE_IDLE_N;
    end
  end

  // read data and flag levels sampled straight from the pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      portRdData <= '0;
      flagIn     <= '0;
      flagUse    <= 1'h0;
    end else begin
      flagIn  <= fl.flagIn;
      flagUse <= selFlag;
      if (extPortWidthMode == adpm_pkg::WIDTH_8BIT) begin
        portRdData <= {adpm_pkg::BYTE_RELEASE, adIn[7:0]};
      end else begin
        portRdData <= adIn;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_flag_select: assert property (
    flagUse == $past(systemControlReg[adpm_pkg::SYSTEM_CONTROL_REG_FLAG_EN] & ~portEnable))
    else $error("flag use does not follow control bit and port enable");
  chk_flag_order: assert property (
    $past(selFlag) |-> adOut == {$past(flagOut[7:0]), $past(flagOut[15:8])})
    else $error("flag to pin order wrong");
  chk_addr8_ale: assert property (
    $past(portEnable & portAle & ~extPortWidthMode & ~selFlag)
      |-> adOut == $past(portAddr[23:8]) && adOe == 16'hFFFF)
    else $error("8-bit address phase wrong");
  chk_data8_phase: assert property (
    $past(portEnable & ~portAle & ~extPortWidthMode & ~selFlag)
      |-> adOut == {$past(portAddr[7:0]), $past(portWrData[7:0])} && adOe[15:8] == 8'hFF)
    else $error("8-bit data phase wrong");
  chk_addr16_ale: assert property (
    $past(portEnable & portAle & extPortWidthMode & ~selFlag)
      |-> adOut == $past(portAddr[15:0]) && adOe == 16'hFFFF)
    else $error("16-bit address phase wrong");
  chk_data16_phase: assert property (
    $past(portEnable & ~portAle & extPortWidthMode & ~selFlag & ~portWrN)
      |-> adOut == $past(portWrData) && adOe == 16'hFFFF)
    else $error("16-bit write data phase wrong");
  chk_strobe_idle: assert property (
    !$past(portEnable) |-> rdOutN && wrOutN && !aleOut)
    else $error("strobes not idle with port off");
  chk_flag_release: assert property (
    $past(selFlag) |-> adOe == {$past(flagOe[7:0]), $past(flagOe[15:8])})
    else $error("port drivers not released in flag use");
  chk_ale_order: assert property (
    aleOut ##1 !aleOut && !$past(selFlag, 2) && $past(portEnable, 2)
      |-> $past(adOe, 1) == 16'hFFFF)
    else $error("address not driven while latch strobe up");

  // released pins: port and flags both off, and the data bytes of a read; a narrow write still drives its data byte
  chk_port_release: assert property (
    $past(!portEnable && !selFlag) |-> adOe == 16'h0000)
    else $error("pins driven with port and flags both off");
  chk_read8_release: assert property (
    $past(portEnable & ~portAle & ~extPortWidthMode & portWrN)
      |-> adOe == 16'hFF00)
    else $error("8-bit read data byte still driven");
  chk_write8_drive: assert property (
    $past(portEnable & ~portAle & ~extPortWidthMode & ~portWrN)
      |-> adOe == 16'hFFFF)
    else $error("8-bit write data byte not driven");
  chk_read16_release: assert property (
    $past(portEnable & ~portAle & extPortWidthMode & portWrN)
      |-> adOe == 16'h0000)
    else $error("16-bit read data bytes still driven");

  // flag use selection and the strobes around it
  chk_use_needs_bit: assert property (
    flagUse |-> $past(systemControlReg[adpm_pkg::SYSTEM_CONTROL_REG_FLAG_EN]))
    else $error("flag use without the control bit");
  chk_port_wins: assert property (
    $past(portEnable) |-> !flagUse)
    else $error("flag use while port enabled");
  chk_flag_strobes: assert property (
    $past(selFlag) |-> !aleOut && rdOutN && wrOutN)
    else $error("strobes not idle in flag use");
  chk_strobe_follow: assert property (
    $past(portEnable) |-> aleOut == $past(portAle) && rdOutN == $past(portRdN)
      && wrOutN == $past(portWrN))
    else $error("strobes do not follow the core");

  // read samples; the edge after reset is skipped, its flops were still held
  chk_read8_data: assert property (
    $past(resetn & ~extPortWidthMode) |-> portRdData == {8'h00, $past(adIn[7:0])})
    else $error("8-bit read data not the low pin byte");
  chk_read16_data: assert property (
    $past(resetn & extPortWidthMode) |-> portRdData == $past(adIn))
    else $error("16-bit read data not all pins");

  // per-pin flag map, kept apart from the byte swap so a slip there shows up
  for (genvar pin = 0; pin < adpm_pkg::PIN_COUNT; pin++) begin : gPinMap
    // flag number of this pin: low pins carry the upper flags
    localparam int FLAG_NO = (pin + adpm_pkg::BYTE_BITS) % adpm_pkg::PIN_COUNT;
    chk_pin_flag: assert property (
      $past(selFlag) |-> adOut[pin] == $past(flagOut[FLAG_NO])
        && adOe[pin] == $past(flagOe[FLAG_NO]))
      else $error("flag value not on its mapped pin");
    chk_flag_pin: assert property (
      $past(resetn) |-> flagIn[FLAG_NO] == $past(adIn[pin]))
      else $error("pin level not on its mapped flag");
  end

  // main scenarios the bench should reach
  cov_flag_mode: cover property (flagUse ##1 flagUse);
  cov_cycle8:    cover property (aleOut && !extPortWidthMode ##1 !aleOut && !wrOutN);
  cov_cycle16:   cover property (aleOut && extPortWidthMode ##1 !aleOut && !rdOutN);
  cov_read8:     cover property (aleOut && !extPortWidthMode ##1 !aleOut && !rdOutN);
  cov_flag_exit: cover property (flagUse ##1 !flagUse);

endmodule : addr_data_pin_mux

// ---- adpm_flag_if.sv ----
// carrier between pin multiplexer and flag remapper
`timescale 1ns/1ps
interface adpm_flag_if;
  logic [15:0] flagOut;
  logic [15:0] flagOe;
  logic [15:0] flagIn;
  logic [15:0] pinOut;
  logic [15:0] pinOe;
  logic [15:0] pinIn;
  modport mapper (input flagOut, input flagOe, input pinIn,
                  output pinOut, output pinOe, output flagIn);
  modport core   (output flagOut, output flagOe, output pinIn,
                  input pinOut, input pinOe, input flagIn);
endinterface : adpm_flag_if

// ---- adpm_flag_map.sv ----
// fixed byte-swapped mapping between flag numbers and pin numbers
`timescale 1ns/1ps
module adpm_flag_map (
  adpm_flag_if.mapper fl
);
  // pin n carries flag n+8 for the low byte, flag n-8 for the high byte
  function automatic logic [15:0] adpmSwap(input logic [15:0] v);
    adpmSwap = {v[7:0], v[15:8]};
  endfunction : adpmSwap

  assign fl.pinOut = adpmSwap(fl.flagOut);
  assign fl.pinOe  = adpmSwap(fl.flagOe);
  assign fl.flagIn = adpmSwap(fl.pinIn);
endmodule : adpm_flag_map

// ---- adpm_latch_mem.sv ----
// partner model: external address latch plus parallel memory
`timescale 1ns/1ps
module adpm_latch_mem (
  input  wire logic        clk_sys,
  input  wire logic        aleOut,
  input  wire logic        rdOutN,
  input  wire logic        wide,
  input  wire logic [15:0] pins,
  output logic      [15:0] memOut,
  output logic      [15:0] memOe
);
  logic [15:0] held;
  always @(posedge clk_sys) begin
    if (aleOut) held <= pins;
  end
  // word is the inverted address, so a stale latch shows as wrong data
  always_comb begin
    memOut = ~held;
    memOe  = rdOutN ? 16'h0000 : (wide ? 16'hFFFF : 16'h00FF);
  end
endmodule : adpm_latch_mem

// ---- adpm_pkg.sv ----
// constants for the address/data pin multiplexer
package adpm_pkg;
  localparam int         PIN_COUNT      = 16;
  localparam int         BYTE_BITS      = 8;
  localparam int         ADDR_BITS      = 24;
  localparam int         SYSTEM_CONTROL_REG_BITS    = 32;
  localparam int         SYSTEM_CONTROL_REG_FLAG_EN = 20;
  localparam logic       WIDTH_8BIT     = 1'h0;
  localparam logic       WIDTH_16BIT    = 1'h1;
  localparam logic [7:0] BYTE_DRIVE     = 8'hFF;
  localparam logic [7:0] BYTE_RELEASE   = 8'h00;
  localparam logic       STROBE_IDLE_N  = 1'h1;
  localparam logic       ALE_IDLE       = 1'h0;
endpackage : adpm_pkg

// ---- tb_top.sv ----
// self-checking bench for the address/data pin multiplexer
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'h0;
  logic        resetn = 1'h0;
  logic [31:0] systemControlReg = '0;
  logic        portEnable = 1'h0;
  logic        extPortWidthMode = 1'h0;
  logic        portAle = 1'h0;
  logic        portRdN = 1'h1;
  logic        portWrN = 1'h1;
  logic [23:0] portAddr = '0;
  logic [15:0] portWrData = '0;
  logic [15:0] flagOut = '0;
  logic [15:0] flagOe = '0;
  logic [15:0] pins, portRdData, flagIn, adOut, adOe, memOut, memOe;
  logic        flagUse, aleOut, rdOutN, wrOutN;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #20 clk_sys = ~clk_sys;
  // pull-ups hold any released pin high
  assign pins = (adOe & adOut) | (~adOe & memOe & memOut) | (~adOe & ~memOe);
  addr_data_pin_mux DUT (.clk_sys(clk_sys), .resetn(resetn),
    .systemControlReg(systemControlReg), .portEnable(portEnable),
    .extPortWidthMode(extPortWidthMode), .portAle(portAle), .portRdN(portRdN),
    .portWrN(portWrN), .portAddr(portAddr), .portWrData(portWrData),
    .portRdData(portRdData), .flagOut(flagOut), .flagOe(flagOe), .flagIn(flagIn),
    .flagUse(flagUse), .adIn(pins), .adOut(adOut), .adOe(adOe), .aleOut(aleOut),
    .rdOutN(rdOutN), .wrOutN(wrOutN));
  adpm_latch_mem PEER (.clk_sys(clk_sys), .aleOut(aleOut), .rdOutN(rdOutN),
    .wide(extPortWidthMode), .pins(pins), .memOut(memOut), .memOe(memOe));
  task automatic results;
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // each edge drives the next inputs, then checks what the previous ones made
  task automatic t_wr8;
    @(posedge clk_sys);
    portEnable <= 1'h1;
    extPortWidthMode <= adpm_pkg::WIDTH_8BIT;
    portAle <= 1'h1;
    portAddr <= 24'hC3A55A;
    portWrData <= 16'h0096;
    @(posedge clk_sys);
    portAle <= 1'h0;
    portWrN <= 1'h0;
    #1 chk("ale8 pins", adOut, 16'hC3A5);
    chk("ale8 oe", adOe, 16'hFFFF);
    chk("ale8 strobes", {aleOut, wrOutN, rdOutN}, 3'h7);
    @(posedge clk_sys);
    portWrN <= 1'h1;
    #1 chk("data8 pins", adOut, 16'h5A96);
    chk("data8 oe", adOe, 16'hFFFF);
    chk("wr strobes", {aleOut, wrOutN, rdOutN}, 3'h1);
    @(posedge clk_sys);
    #1 chk("idle8 oe", adOe, 16'hFF00);
  endtask : t_wr8
  task automatic t_16;
    @(posedge clk_sys);
    extPortWidthMode <= adpm_pkg::WIDTH_16BIT;
    portAle <= 1'h1;
    portAddr <= 24'h7EBEEF;
    @(posedge clk_sys);
    portAle <= 1'h0;
    portWrN <= 1'h0;
    portWrData <= 16'h1234;
    #1 chk("ale16 pins", adOut, 16'hBEEF);
    chk("ale16 oe", adOe, 16'hFFFF);
    @(posedge clk_sys);
    portWrN <= 1'h1;
    portRdN <= 1'h0;
    #1 chk("data16 pins", adOut, 16'h1234);
    chk("data16 oe", adOe, 16'hFFFF);
    @(posedge clk_sys);
    #1 chk("read oe", adOe, 16'h0000);
    chk("rd strobes", {aleOut, wrOutN, rdOutN}, 3'h2);
    @(posedge clk_sys);
    portRdN <= 1'h1;
    #1 chk("read data", portRdData, 16'h4110);
  endtask : t_16
  // narrow read: the low byte comes back from the memory, the latch holds A23-8
  task automatic t_rd8;
    @(posedge clk_sys);
    extPortWidthMode <= adpm_pkg::WIDTH_8BIT;
    portAle <= 1'h1;
    portAddr <= 24'h5AC3E1;
    @(posedge clk_sys);
    portAle <= 1'h0;
    portRdN <= 1'h0;
    #1 chk("ale8 read pins", adOut, 16'h5AC3);
    @(posedge clk_sys);
    portRdN <= 1'h1;
    #1 chk("rd8 addr byte", adOut[15:8], 8'hE1);
    chk("rd8 oe", adOe, 16'hFF00);
    chk("rd8 strobes", {aleOut, wrOutN, rdOutN}, 3'h2);
    @(posedge clk_sys);
    #1 chk("rd8 data", portRdData, 16'h003C);
  endtask : t_rd8
  task automatic t_flag;
    @(posedge clk_sys);
    portEnable <= 1'h0;
    systemControlReg <= 32'h1 << adpm_pkg::SYSTEM_CONTROL_REG_FLAG_EN;
    flagOut <= 16'h12F0;
    flagOe <= 16'h00FF;
    @(posedge clk_sys);
    #1 chk("flag use", flagUse, 1'h1);
    chk("flag pins", adOut, 16'hF012);
    chk("flag oe", adOe, 16'hFF00);
    chk("flag strobes", {aleOut, wrOutN, rdOutN}, 3'h3);
    @(posedge clk_sys);
    portEnable <= 1'h1;
    #1 chk("flag in", flagIn, 16'hFFF0);
    @(posedge clk_sys);
    portEnable <= 1'h0;
    systemControlReg <= 32'hFFEFFFFF;
    #1 chk("port overrides", flagUse, 1'h0);
    @(posedge clk_sys);
    #1 chk("bit clear use", flagUse, 1'h0);
    chk("bit clear oe", adOe, 16'h0000);
  endtask : t_flag
  // limit sits well above the roughly forty cycles the scenarios need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 300) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    chk("reset strobes", {aleOut, wrOutN, rdOutN}, 3'h3);
    resetn <= 1'h1;
    t_wr8();
    t_16();
    t_rd8();
    t_flag();
    results();
  end
endmodule : tb_top
